// [dtb_defs.vh]
// constants for the dma transfer-type and bus-mode sequencer
`ifndef DTB_DEFS_VH
`define DTB_DEFS_VH
// bus-mode field encoding
`define DTB_BM_NORMAL 2'h0
`define DTB_BM_INT16 2'h1
`define DTB_BM_INT64 2'h2
`define DTB_BM_BURST 2'h3
// intermittent hold-off, in bus clocks
`define DTB_HOLD_SHORT 7'h10
`define DTB_HOLD_LONG 7'h40
// request kinds
`define DTB_REQ_AUTO 2'h0
`define DTB_REQ_EXT 2'h1
`define DTB_REQ_PERI 2'h2
// endpoint kinds
`define DTB_EP_ACKDEV 3'h0
`define DTB_EP_EXTMEM 3'h1
`define DTB_EP_MMIO 3'h2
`define DTB_EP_PERI 3'h3
`define DTB_EP_ONCHIP 3'h4
// transfer unit sizes
`define DTB_SZ_BYTE 2'h0
`define DTB_SZ_WORD 2'h1
`define DTB_SZ_LONG 2'h2
`define DTB_SZ_16B 2'h3
// address modes and acknowledge placement
`define DTB_AM_DUAL 1'h0
`define DTB_AM_SINGLE 1'h1
`define DTB_ACK_IN_READ 1'h0
`define DTB_ACK_IN_WRITE 1'h1
`endif

// [dtb_buf2.v]
// two-entry data buffer with valid/ready on both sides
`timescale 1ns/10ps
module dtb_buf2 #(
   parameter WIDTH = 32
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] head_ff;
   reg [WIDTH-1:0] tail_ff;
   reg [1:0] count_ff;
   wire push;
   wire pop;

   assign in_ready_o = (count_ff != 2'h2);
   assign out_valid_o = (count_ff != 2'h0);
   assign out_data_o = head_ff;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // head is always the oldest word, so the drain side reads a flop
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_ff <= 2'h0;
         head_ff <= {WIDTH{1'b0}};
         tail_ff <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push && !pop)
            count_ff <= count_ff + 2'h1;
         else if (pop && !push)
            count_ff <= count_ff - 2'h1;
         if (pop)
         begin
            if (count_ff == 2'h2)
               head_ff <= tail_ff;
            else if (push)
               head_ff <= in_data_i;
            if (push && count_ff == 2'h2)
               tail_ff <= in_data_i;
         end
         else if (push)
         begin
            if (count_ff == 2'h0)
               head_ff <= in_data_i;
            else
               tail_ff <= in_data_i;
         end
      end
   end
endmodule

// [dtb_holdoff.v]
// intermittent-mode hold-off counter
`timescale 1ns/10ps
`include "dtb_defs.vh"
module dtb_holdoff (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // control
   input wire start_i,
   input wire long_i,
   output wire busy_o
);
   reg [6:0] cnt_ff;

   assign busy_o = (cnt_ff != 7'h0);

   always @(posedge clk_i)
   begin
      if (rst_i)
         cnt_ff <= 7'h0;
      else if (start_i)
         cnt_ff <= long_i ? `DTB_HOLD_LONG : `DTB_HOLD_SHORT;
      else if (cnt_ff != 7'h0)
         cnt_ff <= cnt_ff - 7'h1;
   end
endmodule

// [dtb_dma_xfer.v]
// dma channel sequencer: dual/single address transfers and bus-release policy
// Function
// - dual mode does a source read cycle then a destination write cycle.
// - read data waits in an internal buffer until the write cycle drives it.
// - dual mode acknowledge strobe goes with read or write, per channel setting.
// - dual mode accepts auto, external pin and peripheral requests.
// - single mode is one cycle: acknowledge strobe plus memory address together.
// - single mode only ack device with external memory/mmio, external pin request.
// - only listed source/destination pairs allowed; others refused at start.
// - 16-byte units with a peripheral need longword-capable peripheral register.
// - each channel picks cycle-steal or burst from its bus-mode field.
// - cycle-steal normal releases bus after every unit, reacquires on request.
// - normal mode works with any request source and allowed endpoints.
// - intermittent waits 16 or 64 clocks after release before reacquiring.
// - after reacquiring in intermittent mode, a cache refill may defer transfer.
// - intermittent mode works with any request source and allowed endpoints.
// - burst keeps the bus and transfers while request stays high, until the end count is reached.
`timescale 1ns/10ps
`include "dtb_defs.vh"
module dtb_dma_xfer #(
   parameter AW = 32,
   parameter DW = 32,
   parameter CW = 16
) (
   // clock and reset
   input wire CLK_I,
   input wire RST_I,
   // channel control settings
   input wire ADDR_MODE_I,
   input wire ACK_SEL_I,
   input wire [1:0] BUS_MODE_SELECT_I,
   input wire [1:0] REQ_KIND_I,
   input wire [2:0] SRC_KIND_I,
   input wire [2:0] DST_KIND_I,
   input wire [1:0] UNIT_SIZE_I,
   input wire PERI_LONG_OK_I,
   input wire [AW-1:0] SRC_ADR_I,
   input wire [AW-1:0] DST_ADR_I,
   input wire [CW-1:0] XFER_CNT_I,
   // channel start and status
   input wire START_I,
   output wire BUSY_O,
   output reg DONE_O,
   output reg CFG_ERR_O,
   // request and cache refill
   input wire REQ_I,
   input wire REFILL_I,
   // bus mastership
   output wire BUS_REQ_O,
   input wire BUS_GNT_I,
   // bus cycle
   output wire CYC_O,
   output reg WE_O,
   output reg [AW-1:0] ADR_O,
   output wire [DW-1:0] DAT_O,
   input wire [DW-1:0] DAT_I,
   input wire ACK_I,
   output reg TRANSFER_ACK_STROBE_O
);
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ARB = 7'h02;
   localparam [6:0] ST_RD = 7'h04;
   localparam [6:0] ST_WR = 7'h08;
   localparam [6:0] ST_SGL = 7'h10;
   localparam [6:0] ST_REL = 7'h20;
   localparam [6:0] ST_OFF = 7'h40;

   reg [6:0] state_ff;
   reg [6:0] nxt_state;
   reg [CW-1:0] remain_ff;
   reg [CW-1:0] nxt_remain;
   reg nxt_we;
   reg [AW-1:0] nxt_adr;
   reg nxt_tack;
   reg nxt_done;
   reg nxt_cfg_err;
   reg hold_start;
   reg cfg_ok;
   reg src_transfer_ack_strobe;
   reg dst_transfer_ack_strobe;
   wire buf_in_ready;
   wire buf_out_valid;
   wire buf_push;
   wire buf_pop;
   wire hold_busy;
   wire burst;
   wire intermittent;
   wire unit_done;
   wire last_unit;

   // decoded settings and launch values
   wire single_mode;
   wire ack_dev;
   wire hold_long;
   wire sgl_we;
   wire [AW-1:0] sgl_adr;
   wire rd_tack;
   wire wr_tack;
   wire count_zero;
   wire remain_zero;
   wire chain_unit;
   wire grant_usable;
   wire off_go;

   ////////////////////////////////////////////////////////////////////
   // bus-mode decode
   assign burst = (BUS_MODE_SELECT_I == `DTB_BM_BURST);
   assign intermittent = (BUS_MODE_SELECT_I == `DTB_BM_INT16) ||
                         (BUS_MODE_SELECT_I == `DTB_BM_INT64);

   ////////////////////////////////////////////////////////////////////
   // endpoint and request legality, checked once when the channel starts
   always @*
   begin
      src_transfer_ack_strobe = (SRC_KIND_I == `DTB_EP_ACKDEV);
      dst_transfer_ack_strobe = (DST_KIND_I == `DTB_EP_ACKDEV);
      cfg_ok = 1'b1;
      if (SRC_KIND_I > `DTB_EP_ONCHIP || DST_KIND_I > `DTB_EP_ONCHIP)
         cfg_ok = 1'b0;
      // ack device pairs only with external memory or mmio
      if (src_transfer_ack_strobe && !(DST_KIND_I == `DTB_EP_EXTMEM || DST_KIND_I == `DTB_EP_MMIO))
         cfg_ok = 1'b0;
      if (dst_transfer_ack_strobe && !(SRC_KIND_I == `DTB_EP_EXTMEM || SRC_KIND_I == `DTB_EP_MMIO))
         cfg_ok = 1'b0;
      if (SRC_KIND_I == `DTB_EP_ONCHIP)
         cfg_ok = 1'b0;
      if ((src_transfer_ack_strobe || dst_transfer_ack_strobe) && REQ_KIND_I != `DTB_REQ_EXT)
         cfg_ok = 1'b0;
      if (ADDR_MODE_I == `DTB_AM_SINGLE)
      begin
         if (!(src_transfer_ack_strobe || dst_transfer_ack_strobe) || REQ_KIND_I != `DTB_REQ_EXT)
            cfg_ok = 1'b0;
         if (UNIT_SIZE_I == `DTB_SZ_16B)
            cfg_ok = 1'b0;
      end
      else if (REQ_KIND_I > `DTB_REQ_PERI)
         cfg_ok = 1'b0;
      if (UNIT_SIZE_I == `DTB_SZ_16B && !PERI_LONG_OK_I &&
          (SRC_KIND_I == `DTB_EP_PERI || DST_KIND_I == `DTB_EP_PERI))
         cfg_ok = 1'b0;
      // normal and intermittent modes add no restriction of their own
   end

   ////////////////////////////////////////////////////////////////////
   // read data is parked here between the two cycles of a dual transfer
   assign buf_push = (state_ff == ST_RD) && ACK_I;
   assign buf_pop = (state_ff == ST_WR) && ACK_I;

   dtb_buf2 #(
      .WIDTH(DW)
   ) u_buf (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .in_valid_i(buf_push),
      .in_ready_o(buf_in_ready),
      .in_data_i(DAT_I),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_pop),
      .out_data_o(DAT_O)
   );

   dtb_holdoff u_hold (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .start_i(hold_start),
      .long_i(hold_long),
      .busy_o(hold_busy)
   );

   ////////////////////////////////////////////////////////////////////
   // outputs that follow the state directly
   assign BUSY_O = (state_ff != ST_IDLE);
   assign BUS_REQ_O = (state_ff == ST_ARB) || (state_ff == ST_RD) ||
                      (state_ff == ST_WR) || (state_ff == ST_SGL);
   assign CYC_O = (state_ff == ST_RD) || ((state_ff == ST_WR) && buf_out_valid) ||
                  (state_ff == ST_SGL);
   assign unit_done = ((state_ff == ST_WR) && ACK_I && buf_out_valid) ||
                      ((state_ff == ST_SGL) && ACK_I);
   assign last_unit = (remain_ff == {{(CW-1){1'b0}}, 1'b1});

   ////////////////////////////////////////////////////////////////////
   // per-unit launch values, shared by the first unit and burst chaining
   assign single_mode = (ADDR_MODE_I == `DTB_AM_SINGLE);
   assign ack_dev = src_transfer_ack_strobe || dst_transfer_ack_strobe;
   // hold-off length follows the bus-mode field; only used when intermittent
   assign hold_long = (BUS_MODE_SELECT_I == `DTB_BM_INT64);
   // single mode writes memory when the ack device is the source
   assign sgl_we = src_transfer_ack_strobe;
   assign sgl_adr = src_transfer_ack_strobe ? DST_ADR_I : SRC_ADR_I;
   assign rd_tack = (ACK_SEL_I == `DTB_ACK_IN_READ) && ack_dev;
   assign wr_tack = (ACK_SEL_I == `DTB_ACK_IN_WRITE) && ack_dev;
   assign count_zero = (XFER_CNT_I == {CW{1'b0}});
   assign remain_zero = (remain_ff == {CW{1'b0}});
   // a dropped request ends the burst early, like a level request going idle
   assign chain_unit = burst && !last_unit && REQ_I;
   assign grant_usable = BUS_GNT_I && !(intermittent && REFILL_I);
   assign off_go = REQ_I && !hold_busy;

   ////////////////////////////////////////////////////////////////////
   // sequencer
   always @*
   begin
      nxt_state = state_ff;
      nxt_remain = remain_ff;
      nxt_we = WE_O;
      nxt_adr = ADR_O;
      nxt_tack = TRANSFER_ACK_STROBE_O;
      nxt_done = 1'b0;
      nxt_cfg_err = CFG_ERR_O;
      hold_start = 1'b0;
      if (unit_done)
         nxt_remain = remain_ff - {{(CW-1){1'b0}}, 1'b1};
      case (state_ff)
         ST_IDLE:
         begin
            nxt_tack = 1'b0;
            if (START_I)
            begin
               nxt_cfg_err = !cfg_ok || count_zero;
               if (cfg_ok && !count_zero)
               begin
                  nxt_remain = XFER_CNT_I;
                  nxt_state = ST_OFF;
               end
            end
         end
         ST_OFF:
         begin
            // hold-off must run out before the bus is asked for again
            if (off_go)
               nxt_state = ST_ARB;
         end
         ST_ARB:
         begin
            // a refill after reacquiring may push the transfer back
            if (grant_usable)
            begin
               if (single_mode)
               begin
                  nxt_state = ST_SGL;
                  nxt_we = sgl_we;
                  nxt_adr = sgl_adr;
                  nxt_tack = 1'b1;
               end
               else if (buf_in_ready)
               begin
                  nxt_state = ST_RD;
                  nxt_we = 1'b0;
                  nxt_adr = SRC_ADR_I;
                  nxt_tack = rd_tack;
               end
            end
         end
         ST_RD:
         begin
            if (ACK_I)
            begin
               nxt_state = ST_WR;
               nxt_we = 1'b1;
               nxt_adr = DST_ADR_I;
               nxt_tack = wr_tack;
            end
         end
         ST_WR, ST_SGL:
         begin
            if (unit_done)
            begin
               nxt_tack = 1'b0;
               nxt_we = 1'b0;
               // burst chains units on the bus it already owns
               if (chain_unit)
               begin
                  if (single_mode)
                  begin
                     nxt_state = ST_SGL;
                     nxt_we = sgl_we;
                     nxt_adr = sgl_adr;
                     nxt_tack = 1'b1;
                  end
                  else
                  begin
                     nxt_state = ST_RD;
                     nxt_adr = SRC_ADR_I;
                     nxt_tack = rd_tack;
                  end
               end
               else
                  nxt_state = ST_REL;
            end
         end
         ST_REL:
         begin
            // bus request is already low here: the other master gets the bus
            hold_start = intermittent && !remain_zero;
            if (remain_zero)
            begin
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end
            else
               nxt_state = ST_OFF;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         state_ff <= ST_IDLE;
         remain_ff <= {CW{1'b0}};
         WE_O <= 1'b0;
         ADR_O <= {AW{1'b0}};
         TRANSFER_ACK_STROBE_O <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         remain_ff <= nxt_remain;
         WE_O <= nxt_we;
         ADR_O <= nxt_adr;
         TRANSFER_ACK_STROBE_O <= nxt_tack;
      end
   end

   // status flags kept apart so a refused start never disturbs the bus side
   always @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         DONE_O <= 1'b0;
         CFG_ERR_O <= 1'b0;
      end
      else
      begin
         DONE_O <= nxt_done;
         CFG_ERR_O <= nxt_cfg_err;
      end
   end
endmodule

// [dtb_dma_xfer_assertions.sv]
// concurrent checks on the dma sequencer ports
`timescale 1ns/10ps
module dtb_dma_xfer_chk #(
   parameter AW = 32,
   parameter DW = 32,
   parameter CW = 16
) (
   // clock and reset
   input wire CLK_I,
   input wire RST_I,
   // channel settings
   input wire ADDR_MODE_I,
   input wire ACK_SEL_I,
   input wire [1:0] BUS_MODE_SELECT_I,
   input wire [2:0] SRC_KIND_I,
   input wire [2:0] DST_KIND_I,
   input wire [AW-1:0] SRC_ADR_I,
   input wire [AW-1:0] DST_ADR_I,
   // control and status
   input wire START_I,
   input wire BUSY_O,
   input wire DONE_O,
   input wire CFG_ERR_O,
   input wire REQ_I,
   input wire REFILL_I,
   // bus side
   input wire BUS_REQ_O,
   input wire CYC_O,
   input wire WE_O,
   input wire [AW-1:0] ADR_O,
   input wire [DW-1:0] DAT_O,
   input wire [DW-1:0] DAT_I,
   input wire ACK_I,
   input wire TRANSFER_ACK_STROBE_O
);
   ////////////////////////////////////////////////////////////////////////////
   // bus-idle run length; a channel end voids it so a new start may arbitrate at once
   reg [7:0] low_cnt_ff;
   wire unit_end = CYC_O && ACK_I && (WE_O || ADDR_MODE_I);
   wire ack_dev = (SRC_KIND_I == 3'h0) || (DST_KIND_I == 3'h0);
   always @(posedge CLK_I)
   begin
      if (RST_I || DONE_O)
         low_cnt_ff <= 8'hff;
      else if (BUS_REQ_O)
         low_cnt_ff <= 8'h00;
      else if (low_cnt_ff != 8'hff)
         low_cnt_ff <= low_cnt_ff + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_read_then_write: assert property (!ADDR_MODE_I && CYC_O && !WE_O && ACK_I |=> CYC_O && WE_O)
      else $error("write cycle did not follow read");
   a_dual_addr: assert property (!ADDR_MODE_I && CYC_O |-> ADR_O == (WE_O ? DST_ADR_I : SRC_ADR_I))
      else $error("dual cycle address wrong");
   a_buffer_data: assert property (!ADDR_MODE_I && CYC_O && !WE_O && ACK_I |=> DAT_O == $past(DAT_I))
      else $error("write data differs from read data");
   a_dual_strobe: assert property (!ADDR_MODE_I && CYC_O && ack_dev |-> TRANSFER_ACK_STROBE_O == (WE_O == ACK_SEL_I))
      else $error("dual strobe in wrong cycle");
   a_single_cycle: assert property (ADDR_MODE_I && CYC_O |-> TRANSFER_ACK_STROBE_O &&
      ADR_O == (SRC_KIND_I == 3'h0 ? DST_ADR_I : SRC_ADR_I))
      else $error("single cycle strobe or address wrong");
   a_unit_release: assert property (BUS_MODE_SELECT_I != 2'h3 && unit_end |=> !BUS_REQ_O)
      else $error("bus kept after cycle-steal unit");
   a_burst_keep: assert property (BUS_MODE_SELECT_I == 2'h3 && !ADDR_MODE_I && REQ_I && unit_end ##1 !BUS_REQ_O
      |=> DONE_O)
      else $error("burst released bus before end");
   a_hold_off: assert property ($rose(BUS_REQ_O) && (BUS_MODE_SELECT_I == 2'h1 || BUS_MODE_SELECT_I == 2'h2)
      |-> low_cnt_ff >= (BUS_MODE_SELECT_I == 2'h1 ? 8'h10 : 8'h40))
      else $error("intermittent hold-off too short");
   a_refill_defer: assert property ((BUS_MODE_SELECT_I == 2'h1 || BUS_MODE_SELECT_I == 2'h2) && BUS_REQ_O
      && !CYC_O && REFILL_I |=> !CYC_O)
      else $error("cycle started during refill");
   a_start_answer: assert property (START_I && !BUSY_O |=> BUSY_O != CFG_ERR_O)
      else $error("start neither taken nor refused");
endmodule

bind dtb_dma_xfer dtb_dma_xfer_chk #(.AW(AW), .DW(DW), .CW(CW)) dtb_dma_xfer_chk_inst (
   .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_MODE_I(ADDR_MODE_I), .ACK_SEL_I(ACK_SEL_I),
   .BUS_MODE_SELECT_I(BUS_MODE_SELECT_I), .SRC_KIND_I(SRC_KIND_I), .DST_KIND_I(DST_KIND_I),
   .SRC_ADR_I(SRC_ADR_I), .DST_ADR_I(DST_ADR_I), .START_I(START_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
   .CFG_ERR_O(CFG_ERR_O), .REQ_I(REQ_I), .REFILL_I(REFILL_I), .BUS_REQ_O(BUS_REQ_O), .CYC_O(CYC_O),
   .WE_O(WE_O), .ADR_O(ADR_O), .DAT_O(DAT_O), .DAT_I(DAT_I), .ACK_I(ACK_I),
   .TRANSFER_ACK_STROBE_O(TRANSFER_ACK_STROBE_O));

// [dtb_bus_model.sv]
// far-side model: bus arbiter and memory with random waits
`timescale 1ns/10ps
module dtb_bus_model (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // from the sequencer
   input wire bus_req_i,
   input wire cyc_i,
   input wire we_i,
   input wire [31:0] adr_i,
   // to the sequencer
   output reg gnt_o,
   output reg ack_o,
   output reg [31:0] dat_o
);
   reg [31:0] rnd_ff;
   reg [1:0] wait_ff;
   function [31:0] xs(input [31:0] v);
   begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   end
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // read data is only valid with ack; otherwise the bus toggles so stale data never matches
   always @(posedge clk_i)
   begin
      rnd_ff <= rst_i ? 32'h0000_1d2f : xs(rnd_ff);
      gnt_o <= !rst_i && bus_req_i && (gnt_o || rnd_ff[1:0] != 2'h0);
      dat_o <= rst_i ? 32'h0 : (cyc_i && !we_i && !ack_o && wait_ff == 2'h0) ? adr_i ^ 32'h3c3c_a5a5 : ~dat_o;
      if (rst_i || !cyc_i || ack_o)
      begin
         ack_o <= 1'b0;
         wait_ff <= rnd_ff[3:2];
      end
      else if (wait_ff == 2'h0)
         ack_o <= 1'b1;
      else
         wait_ff <= wait_ff - 2'h1;
   end
endmodule

// [dtb_dma_xfer_tb_top.sv]
// self-checking bench for the dma sequencer
`timescale 1ns/10ps
module dtb_dma_xfer_tb_top;
   reg clk, rst, am, asel, plok, start, req, refill, prev_req;
   reg [1:0] bm, rk, sz;
   reg [2:0] sk, dk;
   reg [31:0] sa, da, seed;
   reg [15:0] cnt;
   wire busy, done, err, breq, gnt, cyc, we, ack, strobe;
   wire [31:0] adr, dout, din;
   integer error_cnt, num_checks, units, rels, cycles, t;
   dtb_dma_xfer dtb_dma_xfer_inst (
      .CLK_I(clk), .RST_I(rst), .ADDR_MODE_I(am), .ACK_SEL_I(asel), .BUS_MODE_SELECT_I(bm), .REQ_KIND_I(rk),
      .SRC_KIND_I(sk), .DST_KIND_I(dk), .UNIT_SIZE_I(sz), .PERI_LONG_OK_I(plok), .SRC_ADR_I(sa), .DST_ADR_I(da),
      .XFER_CNT_I(cnt), .START_I(start), .BUSY_O(busy), .DONE_O(done), .CFG_ERR_O(err), .REQ_I(req),
      .REFILL_I(refill), .BUS_REQ_O(breq), .BUS_GNT_I(gnt), .CYC_O(cyc), .WE_O(we), .ADR_O(adr),
      .DAT_O(dout), .DAT_I(din), .ACK_I(ack), .TRANSFER_ACK_STROBE_O(strobe));
   dtb_bus_model dtb_bus_model_inst (.clk_i(clk), .rst_i(rst), .bus_req_i(breq), .cyc_i(cyc), .we_i(we),
      .adr_i(adr), .gnt_o(gnt), .ack_o(ack), .dat_o(din));
   ////////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] v);
   begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   end
   endfunction
   function exp_err(input [2:0] s, input [2:0] d, input m, input [1:0] r, input [1:0] z, input ok,
      input [15:0] n);
      reg a;
      reg [2:0] o;
   begin
      a = (s == 3'h0) || (d == 3'h0);
      o = (s == 3'h0) ? d : s;
      exp_err = (n == 16'h0) || (r == 2'h3) || (s > 3'h3) || (d > 3'h4)
         || (a && ((o != 3'h1 && o != 3'h2) || r != 2'h1)) || (m && (!a || z == 2'h3))
         || (z == 2'h3 && (s == 3'h3 || d == 3'h3) && !ok);
   end
   endfunction
   task check(input [63:0] got, input [63:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   end
   endtask
   task test_done;
   begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // one channel run per combination of endpoints, address mode and request kind
   task run(input integer k);
      reg e;
      integer i;
   begin
      seed = xs(seed);
      @(posedge clk);
      sk <= k / 30;
      dk <= (seed[12:10] == 3'h7) ? 3'h7 : (k / 6) % 5; // corner: illegal endpoint code
      am <= (k / 3) % 2;
      rk <= (k % 3 == 1 && seed[9:8] == 2'h3) ? 2'h3 : k % 3; // corner: illegal request kind
      sz <= seed[1:0];
      bm <= (k % 3 == 2 && seed[3:2] == 2'h3) ? 2'h0 : seed[3:2];
      asel <= seed[4];
      plok <= seed[5];
      cnt <= {14'h0, seed[7:6]};
      sa <= seed ^ 32'h0f0f_0000;
      da <= ~seed;
      start <= 1'b1;
      units = 0;
      rels = 0;
      @(posedge clk);
      start <= 1'b0;
      #1;
      e = exp_err(sk, dk, am, rk, sz, plok, cnt);
      check({busy, err}, {~e, e});
      for (i = 0; i < 4000 && !e && !done; i = i + 1)
      begin
         @(posedge clk);
         seed = xs(seed);
         req <= (bm == 2'h3) || seed[1:0] != 2'h0;
         refill <= seed[2] && seed[3];
         #1;
      end
      if (!e)
         check({done, units[15:0]}, {1'b1, cnt});
      if (!e && !am)
         check(rels, (bm == 2'h3) ? 16'h1 : cnt);
      $display("test %0d done", k);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // a unit ends on an acked write or single cycle; dual-mode data checked against the source pattern
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 90000)
      begin
         error_cnt = error_cnt + 1;
         test_done;
      end
      if (cyc && ack && (we || am))
      begin
         units = units + 1;
         if (!am)
            check(dout, sa ^ 32'h3c3c_a5a5);
      end
      if (prev_req && !breq)
         rels = rels + 1;
      prev_req = breq;
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {am, asel, plok, start, req, refill, prev_req} = 7'h0;
      {bm, rk, sz, sk, dk, cnt, sa, da} = 0;
      error_cnt = 0;
      num_checks = 0;
      units = 0;
      rels = 0;
      cycles = 0;
      seed = 32'h43;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (t = 0; t < 150; t = t + 1)
         run(t);
      test_done;
   end
endmodule
